// File: rtl/boot_loader.sv
`timescale 1ns/10ps
// Contract
// R1 - Boot source codes 0b11 or 0b10 start execution from ROM.
// R2 - Boot source select comes from option byte bits 7:6 at 0x40D.
// R3 - Boot config pin forces ROM only when boot pin option bit is zero.
// R4 - Erased option byte reads all ones and so boots ROM.
// R5 - NMI stays masked while ROM started out of reset runs.
// R6 - Vector fetches redirect to ROM table at 0x1C00_0000 during ROM boot.
// R7 - First step sets force-ROM in reset controller mode register.
// R8 - After memory init, read configuration record from flash at 0x3C0.
// R9 - Record valid only if first four bytes are k, c, f, g.
// R10 - Invalid tag makes every value default, as if bytes were 0xFF.
// R11 - Byte 0x10 bit0 UART, bit1 I2C, bit2 SPI enables.
// R12 - Byte 0x11, unless 0xFF, is the seven-bit I2C target address.
// R13 - Bytes 0x12-0x13 give detection timeout in milliseconds.
// R14 - Clock flags active low; bit 0 clear selects high-speed mode.
// R15 - Byte 0x1D is core and bus divider, used only in high-speed.
// R16 - Configure clocks, then init enabled peripherals, then await activity.
// R17 - No activity before timeout: exit to flash application.
// R18 - Activity on one peripheral shuts others and enters command phase.
// R19 - Invalid record enables every supported peripheral.
// R20 - High-speed clear flag enables fast reference clock before init.
// R21 - Multi-byte fields assemble lower offset as least significant byte.
module boot_loader #(
  parameter int CYCLES_PER_MS = boot_pkg::CYCLES_PER_MS
) (
  input  wire logic        clk,              // System clock.
  input  wire logic        resetn,           // Async reset, active low.
  output logic             flash_re,         // Flash read strobe.
  output logic      [11:0] flash_addr,       // Flash byte address.
  input  wire logic [7:0]  flash_data,       // Flash read data.
  input  wire logic        flash_ack,        // Flash data valid.
  input  wire logic        boot_config_pin,  // Boot pin, active high.
  input  wire logic        mem_init_done,    // Working memory initialised.
  input  wire logic        vector_fetch,     // CPU fetching a vector.
  input  wire logic [31:0] vector_addr,      // Vector address from CPU.
  output logic      [31:0] vector_addr_out,  // Redirected vector address.
  input  wire logic        nmi_in,           // NMI request from pin.
  output logic             nmi_out,          // NMI after masking.
  output logic             rom_boot,         // Level: ROM boot chosen.
  output logic             force_rom_boot,   // Reset ctrl force-ROM bit.
  output logic             mem_init_start,   // Level: init working memory.
  output logic      [2:0]  peripheral_enable_mask, // UART, I2C, SPI.
  output logic      [6:0]  target_address_override, // I2C address.
  output logic             addr_override_valid,    // Address is used.
  output logic      [15:0] detect_timeout_ms, // Detection timeout.
  output logic      [7:0]  clock_option_flags, // Raw clock flags.
  output logic             fast_clock_flag,  // High-speed mode selected.
  output logic      [7:0]  core_bus_divider, // Divider in high-speed.
  output logic             fast_ref_clk_en,  // Fast reference clock on.
  output logic             config_valid,     // Record tag matched.
  output logic      [2:0]  periph_init,      // Peripherals initialised.
  input  wire logic [2:0]  periph_active,    // Activity per peripheral.
  output logic      [2:0]  periph_selected,  // Peripheral kept alive.
  output logic             command_phase,    // Level: command phase.
  output logic             exit_to_app       // Level: jump to flash app.
);
  typedef enum logic [3:0] {
    ST_OPT    = 4'h0,
    ST_DECIDE = 4'h1,
    ST_FORCE  = 4'h2,
    ST_MEM    = 4'h3,
    ST_READ   = 4'h4,
    ST_WAIT   = 4'h5,
    ST_CLOCK  = 4'h6,
    ST_INIT   = 4'h7,
    ST_DETECT = 4'h8,
    ST_CMD    = 4'h9,
    ST_EXIT   = 4'ha
  } state_e;

  state_e      state_r;
  state_e      state_nxt;
  logic [4:0]  idx_r;
  logic        rd_start;
  logic [11:0] rd_addr;
  logic        rd_done;
  logic [7:0]  rd_data;
  logic        tag_ok_r;
  logic [7:0]  periph_byte_r;
  logic [7:0]  addr_byte_r;
  logic [7:0]  tmo_lo_r;
  logic [7:0]  tmo_hi_r;
  logic [7:0]  clk_byte_r;
  logic [7:0]  div_byte_r;
  logic        tmr_load;
  logic        tmr_expired;
  logic [7:0]  tag_exp;
  logic [7:0]  eff_byte;
  logic [2:0]  pick;
  logic        rec_take;
  logic        tag_slot;
  logic        opt_done;
  logic        det_hit;
  logic        det_tmo;
  logic        rom_running;

  always_comb begin
    case (idx_r[1:0])
      2'd0:    tag_exp = boot_pkg::TAG_K;
      2'd1:    tag_exp = boot_pkg::TAG_C;
      2'd2:    tag_exp = boot_pkg::TAG_F;
      default: tag_exp = boot_pkg::TAG_G;
    endcase
  end

  flash_byte_reader u_rd (
    .clk        (clk),
    .resetn     (resetn),
    .start      (rd_start),
    .addr       (rd_addr),
    .flash_re   (flash_re),
    .flash_addr (flash_addr),
    .flash_data (flash_data),
    .flash_ack  (flash_ack),
    .done       (rd_done),
    .data_r     (rd_data)
  );

  ms_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_tmr (
    .clk     (clk),
    .resetn  (resetn),
    .load    (tmr_load),
    .ms      (detect_timeout_ms),
    .stop    (state_r != ST_DETECT),
    .expired (tmr_expired)
  );

  assign rd_start = (state_r == ST_OPT && idx_r == 5'h0)
                 || (state_r == ST_READ);
  assign rd_addr  = (state_r == ST_OPT) ? boot_pkg::OPT_ADDR
                  : boot_pkg::CFG_BASE + {7'h00, idx_r}; // see R8
  assign tmr_load = (state_r == ST_INIT);
  // Invalid record reads as erased bytes.
  assign eff_byte = tag_ok_r ? rd_data : boot_pkg::ERASED; // see R10
  assign opt_done = (state_r == ST_OPT) && rd_done;
  assign rec_take = (state_r == ST_WAIT) && rd_done;
  assign tag_slot = rec_take && (idx_r <= boot_pkg::OFS_TAG3);
  assign det_hit  = (state_r == ST_DETECT) && (pick != 3'b000);
  assign det_tmo  = (state_r == ST_DETECT) && tmr_expired;

  // Lowest-numbered active enabled peripheral wins.
  always_comb begin
    pick = 3'b000;
    for (int i = 0; i < 3; i++) begin
      if (pick == 3'b000 && periph_active[i] && periph_init[i]) begin
        pick[i] = 1'b1;
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OPT:    if (rd_done) state_nxt = ST_DECIDE;
      ST_DECIDE: state_nxt = rom_boot ? ST_FORCE : ST_EXIT;
      ST_FORCE:  state_nxt = ST_MEM; // see R7
      ST_MEM:    if (mem_init_done) state_nxt = ST_READ; // see R8
      ST_READ:   state_nxt = ST_WAIT;
      ST_WAIT: begin
        if (rd_done) begin
          state_nxt = (idx_r == boot_pkg::CFG_LEN - 5'h1) ? ST_CLOCK
                                                           : ST_READ;
        end
      end
      ST_CLOCK:  state_nxt = ST_INIT; // see R16
      ST_INIT:   state_nxt = ST_DETECT; // see R16
      ST_DETECT: begin
        if (pick != 3'b000) begin
          state_nxt = ST_CMD; // see R18
        end else if (tmr_expired) begin
          state_nxt = ST_EXIT; // see R17
        end
      end
      ST_CMD:    state_nxt = ST_CMD;
      ST_EXIT:   state_nxt = ST_EXIT;
      default:   state_nxt = ST_OPT;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_OPT;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idx_r <= 5'h0;
    end else if (state_r == ST_OPT) begin
      idx_r <= 5'h1;
    end else if (state_r == ST_MEM) begin
      idx_r <= 5'h0;
    end else if (state_r == ST_WAIT && rd_done) begin
      idx_r <= idx_r + 5'h1;
    end
  end

  // Erased option byte is all ones, so source is 0b11 and ROM boots.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rom_boot <= 1'b0;
    end else if (opt_done) begin
      rom_boot <= rd_data[boot_pkg::SRC_HI] // see R1 R2 R4
               || (boot_config_pin
                   && !rd_data[boot_pkg::PIN_OPT_BIT]); // see R3
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      force_rom_boot <= 1'b0;
    end else if (state_r == ST_FORCE) begin
      force_rom_boot <= 1'b1; // see R7
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_init_start <= 1'b0;
    end else begin
      mem_init_start <= (state_nxt == ST_MEM); // see R8
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tag_ok_r <= 1'b1;
    end else if (state_r == ST_MEM) begin
      tag_ok_r <= 1'b1;
    end else if (tag_slot && rd_data != tag_exp) begin
      tag_ok_r <= 1'b0; // see R9
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      periph_byte_r <= boot_pkg::ERASED;
    end else if (rec_take && idx_r == boot_pkg::OFS_PERIPH) begin
      periph_byte_r <= eff_byte; // see R11 R19
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_byte_r <= boot_pkg::ERASED;
    end else if (rec_take && idx_r == boot_pkg::OFS_ADDR) begin
      addr_byte_r <= eff_byte; // see R12
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tmo_lo_r <= boot_pkg::ERASED;
    end else if (rec_take && idx_r == boot_pkg::OFS_TMO_LO) begin
      tmo_lo_r <= eff_byte; // see R13
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tmo_hi_r <= boot_pkg::ERASED;
    end else if (rec_take && idx_r == boot_pkg::OFS_TMO_HI) begin
      tmo_hi_r <= eff_byte; // see R13
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk_byte_r <= boot_pkg::ERASED;
    end else if (rec_take && idx_r == boot_pkg::OFS_CLKFLAGS) begin
      clk_byte_r <= eff_byte; // see R14
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_byte_r <= boot_pkg::ERASED;
    end else if (rec_take && idx_r == boot_pkg::OFS_DIVIDER) begin
      div_byte_r <= eff_byte; // see R15
    end
  end

  assign config_valid            = tag_ok_r;
  assign peripheral_enable_mask  = periph_byte_r[2:0]; // see R11
  assign target_address_override = addr_byte_r[6:0];
  assign addr_override_valid     = (addr_byte_r != boot_pkg::ERASED); // see R12
  assign detect_timeout_ms       = {tmo_hi_r, tmo_lo_r}; // see R21
  assign clock_option_flags      = clk_byte_r;
  assign fast_clock_flag = !clk_byte_r[boot_pkg::FAST_CLOCK_BIT]; // see R14

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fast_ref_clk_en <= 1'b0;
    end else if (state_r == ST_CLOCK && fast_clock_flag) begin
      fast_ref_clk_en <= 1'b1; // see R20
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      core_bus_divider <= 8'h00;
    end else if (state_r == ST_CLOCK && fast_clock_flag) begin
      core_bus_divider <= div_byte_r; // see R15
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      periph_init <= 3'b000;
    end else if (state_r == ST_INIT) begin
      periph_init <= peripheral_enable_mask; // see R16
    end else if (det_hit) begin
      periph_init <= pick; // see R18
    end else if (det_tmo) begin
      periph_init <= 3'b000; // see R17
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      periph_selected <= 3'b000;
    end else if (det_hit) begin
      periph_selected <= pick; // see R18
    end
  end

  assign command_phase = (state_r == ST_CMD);
  assign exit_to_app   = (state_r == ST_EXIT);

  // ROM keeps NMI off and owns every vector until it hands over.
  assign rom_running = rom_boot && !exit_to_app;
  assign nmi_out     = nmi_in && !rom_running; // see R5

  always_comb begin
    vector_addr_out = vector_addr;
    if (rom_running && vector_fetch) begin
      vector_addr_out = boot_pkg::ROM_VECTOR_BASE
                      | {24'h0, vector_addr[7:0]}; // see R6
    end
  end
endmodule : boot_loader

// File: rtl/boot_pkg.sv
package boot_pkg;
  localparam logic [11:0] OPT_ADDR        = 12'h40d;
  localparam int          SRC_HI          = 7;
  localparam int          SRC_LO          = 6;
  localparam int          PIN_OPT_BIT     = 5;
  localparam logic [11:0] CFG_BASE        = 12'h3c0;
  localparam logic [4:0]  CFG_LEN         = 5'h1e;
  localparam logic [4:0]  OFS_TAG3        = 5'h03;
  localparam logic [4:0]  OFS_PERIPH      = 5'h10;
  localparam logic [4:0]  OFS_ADDR        = 5'h11;
  localparam logic [4:0]  OFS_TMO_LO      = 5'h12;
  localparam logic [4:0]  OFS_TMO_HI      = 5'h13;
  localparam logic [4:0]  OFS_CLKFLAGS    = 5'h1c;
  localparam logic [4:0]  OFS_DIVIDER     = 5'h1d;
  localparam logic [7:0]  TAG_K           = 8'h6b;
  localparam logic [7:0]  TAG_C           = 8'h63;
  localparam logic [7:0]  TAG_F           = 8'h66;
  localparam logic [7:0]  TAG_G           = 8'h67;
  localparam logic [7:0]  ERASED          = 8'hff;
  localparam int          PERIPH_UART     = 0;
  localparam int          PERIPH_I2C      = 1;
  localparam int          PERIPH_SPI      = 2;
  localparam int          FAST_CLOCK_BIT  = 0;
  localparam logic [31:0] ROM_VECTOR_BASE = 32'h1c00_0000;
  localparam int          CLK_HZ          = 40_000_000;
  localparam int          MS_PER_S        = 1000;
  localparam int          CYCLES_PER_MS   = CLK_HZ / MS_PER_S;
  localparam int          FLASH_LATENCY   = 1;
endpackage : boot_pkg

// File: rtl/flash_byte_reader.sv
`timescale 1ns/10ps
// Issues one flash byte read and returns the byte from a register.
module flash_byte_reader (
  input  wire logic        clk,        // System clock.
  input  wire logic        resetn,     // Asynchronous reset, active low.
  input  wire logic        start,      // Pulse: begin a read.
  input  wire logic [11:0] addr,       // Byte address to read.
  output logic             flash_re,   // Flash read strobe.
  output logic      [11:0] flash_addr, // Flash address.
  input  wire logic [7:0]  flash_data, // Flash read data.
  input  wire logic        flash_ack,  // Flash data valid.
  output logic             done,       // Pulse: data_r is valid.
  output logic      [7:0]  data_r      // Captured byte.
);
  logic busy_r;

  assign flash_re = busy_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_r     <= 1'b0;
      flash_addr <= 12'h000;
    end else if (start) begin
      busy_r     <= 1'b1;
      flash_addr <= addr;
    end else if (busy_r && flash_ack) begin
      busy_r     <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done   <= 1'b0;
      data_r <= 8'h00;
    end else begin
      done <= busy_r && flash_ack;
      if (busy_r && flash_ack) begin
        data_r <= flash_data;
      end
    end
  end
endmodule : flash_byte_reader

// File: rtl/ms_timer.sv
`timescale 1ns/10ps
// Counts whole milliseconds; expired rises once the loaded count elapses.
module ms_timer #(
  parameter int CYCLES_PER_MS = boot_pkg::CYCLES_PER_MS
) (
  input  wire logic        clk,     // System clock.
  input  wire logic        resetn,  // Asynchronous reset, active low.
  input  wire logic        load,    // Pulse: load ms and start.
  input  wire logic [15:0] ms,      // Timeout in milliseconds.
  input  wire logic        stop,    // Halt counting.
  output logic             expired  // Level: timeout reached.
);
  logic [31:0] tick_r;
  logic [15:0] ms_r;
  logic        run_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_r  <= 32'h0;
      ms_r    <= 16'h0;
      run_r   <= 1'b0;
      expired <= 1'b0;
    end else if (load) begin
      tick_r  <= 32'h0;
      ms_r    <= ms;
      run_r   <= 1'b1;
      expired <= 1'b0;
    end else if (stop) begin
      run_r <= 1'b0;
    end else if (run_r) begin
      if (ms_r == 16'h0) begin
        expired <= 1'b1;
        run_r   <= 1'b0;
      end else if (tick_r == 32'(CYCLES_PER_MS - 1)) begin
        tick_r <= 32'h0;
        ms_r   <= ms_r - 16'h1;
      end else begin
        tick_r <= tick_r + 32'h1;
      end
    end
  end
endmodule : ms_timer

// File: tb/boot_loader_properties.sv
`timescale 1ns/10ps
module boot_loader_properties (
  input wire logic        clk,                    // System clock.
  input wire logic        resetn,                 // Reset, active low.
  input wire logic        flash_re,               // Flash read strobe.
  input wire logic [11:0] flash_addr,             // Flash address.
  input wire logic        vector_fetch,           // Vector fetch.
  input wire logic [31:0] vector_addr,            // CPU vector address.
  input wire logic [31:0] vector_addr_out,        // Redirected address.
  input wire logic        nmi_out,                // Masked NMI.
  input wire logic        rom_boot,               // ROM boot chosen.
  input wire logic        force_rom_boot,         // Force-ROM bit.
  input wire logic        mem_init_start,         // Memory init.
  input wire logic [2:0]  peripheral_enable_mask, // Enable mask.
  input wire logic [15:0] detect_timeout_ms,      // Detection timeout.
  input wire logic [7:0]  clock_option_flags,     // Clock flags.
  input wire logic        fast_clock_flag,        // High-speed mode.
  input wire logic        fast_ref_clk_en,        // Fast clock on.
  input wire logic        config_valid,           // Record tag matched.
  input wire logic [2:0]  periph_init,            // Peripherals up.
  input wire logic [2:0]  periph_selected,        // Kept peripheral.
  input wire logic        command_phase,          // Command phase.
  input wire logic        exit_to_app             // Exit to app.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic rom_run;
  logic fin;
  assign rom_run = rom_boot && !exit_to_app;
  assign fin = rom_boot && (command_phase || exit_to_app);
  property p_opt_read;
    flash_re && !rom_boot && !exit_to_app |-> flash_addr == 12'h40d;
  endproperty
  a_opt_read: assert property (p_opt_read)
    else $error("option read at wrong address");
  property p_rec_read;
    flash_re && force_rom_boot |-> flash_addr inside {[12'h3c0:12'h3dd]};
  endproperty
  a_rec_read: assert property (p_rec_read)
    else $error("record read outside record");
  property p_mem_init;
    mem_init_start |-> force_rom_boot && !flash_re;
  endproperty
  a_mem_init: assert property (p_mem_init)
    else $error("flash read during memory init");
  property p_force;
    $rose(rom_boot) |-> ##[1:4] force_rom_boot;
  endproperty
  a_force: assert property (p_force)
    else $error("force rom bit not set");
  property p_nmi;
    rom_run |-> !nmi_out;
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("nmi passed during rom run");
  property p_vec;
    rom_run && vector_fetch |->
      vector_addr_out == (32'h1c00_0000 | {24'h0, vector_addr[7:0]});
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector not redirected");
  property p_flag;
    fin |-> fast_clock_flag == !clock_option_flags[0];
  endproperty
  a_flag: assert property (p_flag)
    else $error("fast flag polarity wrong");
  property p_ref;
    fast_ref_clk_en |-> fast_clock_flag;
  endproperty
  a_ref: assert property (p_ref)
    else $error("fast clock on without flag");
  property p_ref_first;
    periph_init != 3'h0 && fast_clock_flag |-> fast_ref_clk_en;
  endproperty
  a_ref_first: assert property (p_ref_first)
    else $error("peripherals up before fast clock");
  property p_init;
    (periph_init & ~peripheral_enable_mask) == 3'h0;
  endproperty
  a_init: assert property (p_init)
    else $error("disabled peripheral initialised");
  property p_sel;
    command_phase |-> $onehot(periph_selected) &&
      (periph_selected & ~peripheral_enable_mask) == 3'h0;
  endproperty
  a_sel: assert property (p_sel)
    else $error("bad peripheral selection");
  property p_inval;
    fin && !config_valid |->
      peripheral_enable_mask == 3'h7 && detect_timeout_ms == 16'hffff;
  endproperty
  a_inval: assert property (p_inval)
    else $error("invalid record not defaulted");
  c_cmd: cover property (command_phase && !config_valid);
  c_tmo: cover property (exit_to_app && rom_boot);
  c_app: cover property (exit_to_app && !rom_boot);
endmodule : boot_loader_properties
bind boot_loader boot_loader_properties i_boot_loader_properties (
  .clk, .resetn, .flash_re, .flash_addr, .vector_fetch, .vector_addr,
  .vector_addr_out, .nmi_out, .rom_boot, .force_rom_boot, .mem_init_start,
  .peripheral_enable_mask, .detect_timeout_ms, .clock_option_flags,
  .fast_clock_flag, .fast_ref_clk_en, .config_valid, .periph_init,
  .periph_selected, .command_phase, .exit_to_app);

// File: tb/boot_loader_tb.sv
`timescale 1ns/10ps
module boot_loader_tb;
  logic        clk, resetn, flash_re, flash_ack, boot_config_pin;
  logic        mem_init_done, vector_fetch, nmi_in, nmi_out, rom_boot;
  logic        force_rom_boot, mem_init_start, addr_override_valid;
  logic        fast_clock_flag, fast_ref_clk_en, config_valid;
  logic        command_phase, exit_to_app;
  logic [2:0]  peripheral_enable_mask, periph_init, periph_active;
  logic [2:0]  periph_selected;
  logic [6:0]  target_address_override;
  logic [7:0]  flash_data, clock_option_flags, core_bus_divider;
  logic [11:0] flash_addr;
  logic [15:0] detect_timeout_ms;
  logic [31:0] vector_addr, vector_addr_out;
  int          err_total, comparisons, n;
  boot_loader #(.CYCLES_PER_MS(4)) i_boot_loader (
    .clk, .resetn, .flash_re, .flash_addr, .flash_data, .flash_ack,
    .boot_config_pin, .mem_init_done, .vector_fetch, .vector_addr,
    .vector_addr_out, .nmi_in, .nmi_out, .rom_boot, .force_rom_boot,
    .mem_init_start, .peripheral_enable_mask, .target_address_override,
    .addr_override_valid, .detect_timeout_ms, .clock_option_flags,
    .fast_clock_flag, .core_bus_divider, .fast_ref_clk_en, .config_valid,
    .periph_init, .periph_active, .periph_selected, .command_phase,
    .exit_to_app);
  flash_model i_flash_model (
    .clk, .flash_re, .flash_addr, .flash_data, .flash_ack);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) mem_init_done <= #1 mem_init_start;
  task automatic end_of_test();
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Programs option byte and record, resets, and runs to the final state.
  task automatic load(input logic [7:0] opt, input logic [7:0] t3,
                      input logic [7:0] en, input logic [7:0] ad,
                      input logic [15:0] tmo, input logic [7:0] cf,
                      input logic pin, input logic [2:0] act);
    resetn = 1'b0;
    i_flash_model.mem[12'h40d] = opt;
    i_flash_model.mem[12'h3c0] = 8'h6b;
    i_flash_model.mem[12'h3c1] = 8'h63;
    i_flash_model.mem[12'h3c2] = 8'h66;
    i_flash_model.mem[12'h3c3] = t3;
    i_flash_model.mem[12'h3d0] = en;
    i_flash_model.mem[12'h3d1] = ad;
    i_flash_model.mem[12'h3d2] = tmo[7:0];
    i_flash_model.mem[12'h3d3] = tmo[15:8];
    i_flash_model.mem[12'h3dc] = cf;
    i_flash_model.mem[12'h3dd] = 8'h05;
    boot_config_pin = pin;
    periph_active = act;
    repeat (8) @(posedge clk);
    #1 resetn = 1'b1;
    n = 0;
    while (!(command_phase === 1'b1 || exit_to_app === 1'b1)) begin
      @(posedge clk);
      #1 n++;
      if (n > 3000) begin
        check(1'b0, 1'b1);
        end_of_test();
      end
    end
  endtask : load
  initial begin
    err_total = 0;
    comparisons = 0;
    resetn = 1'b0;
    boot_config_pin = 1'b0;
    vector_fetch = 1'b1;
    vector_addr = 32'h0000_0008;
    nmi_in = 1'b1;
    periph_active = 3'h0;
    // Let the flash model fill its array before the record is written.
    @(posedge clk);
    #1;
    load(8'h1f, 8'h67, 8'h07, 8'hff, 16'h0001, 8'hff, 1'b0, 3'h0);
    check(rom_boot, 1'b0);
    check(force_rom_boot, 1'b0);
    check(nmi_out, 1'b1);
    load(8'h7f, 8'h67, 8'h07, 8'hff, 16'h0001, 8'hff, 1'b1, 3'h0);
    check(rom_boot, 1'b0);
    load(8'h1f, 8'h67, 8'h02, 8'h2a, 16'h0102, 8'hff, 1'b1, 3'h0);
    check(rom_boot, 1'b1);
    check(force_rom_boot, 1'b1);
    check(config_valid, 1'b1);
    check(peripheral_enable_mask, 3'h2);
    check(target_address_override, 7'h2a);
    check(addr_override_valid, 1'b1);
    check(detect_timeout_ms, 16'h0102);
    check(n >= 1032 && n < 1200, 1'b1);
    check(fast_ref_clk_en, 1'b0);
    check(core_bus_divider, 8'h00);
    check(periph_init, 3'h0);
    check(exit_to_app, 1'b1);
    check(command_phase, 1'b0);
    load(8'h80, 8'h67, 8'h06, 8'hff, 16'h0003, 8'hfe, 1'b0, 3'h7);
    check(rom_boot, 1'b1);
    check(addr_override_valid, 1'b0);
    check(fast_clock_flag, 1'b1);
    check(fast_ref_clk_en, 1'b1);
    check(core_bus_divider, 8'h05);
    check(clock_option_flags, 8'hfe);
    check(periph_init, 3'h2);
    check(periph_selected, 3'h2);
    check(command_phase, 1'b1);
    check(nmi_out, 1'b0);
    check(vector_addr_out, 32'h1c00_0008);
    load(8'hff, 8'h68, 8'h01, 8'h10, 16'h0003, 8'hfe, 1'b0, 3'h5);
    check(rom_boot, 1'b1);
    check(config_valid, 1'b0);
    check(peripheral_enable_mask, 3'h7);
    check(detect_timeout_ms, 16'hffff);
    check(fast_clock_flag, 1'b0);
    check(addr_override_valid, 1'b0);
    check(periph_selected, 3'h1);
    end_of_test();
  end
endmodule : boot_loader_tb

// File: tb/flash_model.sv
`timescale 1ns/10ps
// Flash array model; answers each read one cycle after the strobe rises.
module flash_model (
  input  wire logic        clk,        // System clock.
  input  wire logic        flash_re,   // Read strobe.
  input  wire logic [11:0] flash_addr, // Byte address.
  output logic      [7:0]  flash_data, // Read data.
  output logic             flash_ack   // Data valid.
);
  logic [7:0] mem [0:4095];
  logic [7:0] last_r;
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'hff;
  end
  always @(posedge clk) begin
    flash_ack <= #1 flash_re && !flash_ack;
    if (flash_re && !flash_ack) last_r <= #1 mem[flash_addr];
  end
  // Outside an answer the data lines show the inverse of the last byte.
  assign flash_data = flash_ack ? last_r : ~last_r;
endmodule : flash_model
